// ---- common/psr_defs.vh ----
`ifndef PSR_DEFS_VH
`define PSR_DEFS_VH
// register offsets (byte addresses)
`define PSR_OFS_DATA 4'h0
`define PSR_OFS_DSR 4'h1
`define PSR_OFS_DCR 4'h2
`define PSR_OFS_FIFO 4'h3
`define PSR_OFS_CAP 4'h4
`define PSR_OFS_ECR 4'h5
`define PSR_OFS_IRQ_STAT 4'h6
`define PSR_OFS_IRQ_MASK 4'h7
// dcr fields
`define PSR_DCR_STROBE 0
`define PSR_DCR_AUTOFD 1
`define PSR_DCR_INIT 2
`define PSR_DCR_SELIN 3
`define PSR_DCR_DIR 5
// ecr fields
`define PSR_ECR_MODE_HI 7
`define PSR_ECR_MODE_LO 5
`define PSR_ECR_ERRDIS 4
`define PSR_ECR_DMAEN 3
`define PSR_ECR_SVC 2
`define PSR_ECR_FULL 1
`define PSR_ECR_EMPTY 0
// modes
`define PSR_MODE_STD 3'h0
`define PSR_MODE_BYTE 3'h1
`define PSR_MODE_ECP 3'h3
// reset values
`define PSR_ECR_RST 8'h35
`define PSR_DCR_RST 8'h04
// irq status bits
`define PSR_IRQ_FAULT 0
`define PSR_IRQ_SVC 1
`define PSR_IRQ_STALL 2
// timing
`define PSR_CLK_MHZ 40
`define PSR_STROBE_NS 500
`define PSR_STROBE_CYC ((`PSR_STROBE_NS * `PSR_CLK_MHZ + 999) / 1000)
`define PSR_TIMEOUT_MS 1000
`define PSR_TIMEOUT_CYC (`PSR_TIMEOUT_MS * `PSR_CLK_MHZ * 1000)
`endif

// ---- design/psr_port.v ----
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// RULE1 - strobe driven low by software blocks any further data transfer
// RULE2 - host counts free slots by filling fifo until full
// RULE3 - head port word may be partly sent when transfer abandoned
// RULE4 - mode 001 write resets fifo and latches head residue in cap 1:0
// RULE5 - cap bit 2 low when a byte waits in the transceiver stage
// RULE6 - cap 1:0 give partial head word byte count
// RULE7 - host sets direction, drives init low, waits pe low
// RULE8 - host raises strobe, raises init, waits pe high
// RULE9 - host sums whole words, partial bytes and transceiver byte
// RULE10 - mode 001 or 000 during abort resets fifo, standard mode
// RULE11 - abort in reverse direction only needs renegotiation
// RULE12 - transfer time-out in seconds reports a stall
// RULE13 - fault request interrupt is level triggered, any time
// RULE14 - cap bit 7 set: fault irq may coexist with service irq
// RULE15 - cap bit 7 clear: host masks fault irq and polls
// RULE16 - host always able to report fault requests
// RULE17 - mode 001 is byte mode, 011 is enhanced hardware mode
// RULE18 - writing 0x74 to ecr masks service and error interrupts
// RULE19 - full flag asserts exactly at full depth
`include "psr_defs.vh"
module psr_port #(
    parameter WORD_BYTES = 1,
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter FAULT_WITH_SVC = 1'b1,
    parameter TIMEOUT_CYC = `PSR_TIMEOUT_CYC
) (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output wire [7:0] o_pd_out,
    output wire o_pd_oe,
    input wire [7:0] i_pd_in,
    output wire o_nstrobe,
    output wire o_nautofd,
    output wire o_ninit,
    output wire o_nselectin,
    input wire i_nack,
    input wire i_busy,
    input wire i_pe,
    input wire i_select,
    input wire i_nfault,
    output wire o_irq
);
    localparam WB = WORD_BYTES * 8;
    localparam [1:0] LAST_B = WORD_BYTES - 1;
    localparam [AW:0] FULL_CNT = DEPTH;
    localparam [15:0] STB_CYC = `PSR_STROBE_CYC;
    localparam TX_IDLE = 2'h0;
    localparam TX_SETUP = 2'h1;
    localparam TX_STROBE = 2'h2;
    localparam TX_WAIT = 2'h3;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire nack_s;
    wire busy_s;
    wire pe_s;
    wire sel_s;
    wire nfault_s;
    psr_sync3 #(.RST_VAL(1'b1)) u_s_ack (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_ce(i_ce), .i_pin(i_nack), .o_level(nack_s));
    psr_sync3 #(.RST_VAL(1'b0)) u_s_busy (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_ce(i_ce), .i_pin(i_busy), .o_level(busy_s));
    psr_sync3 #(.RST_VAL(1'b0)) u_s_pe (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_ce(i_ce), .i_pin(i_pe), .o_level(pe_s));
    psr_sync3 #(.RST_VAL(1'b0)) u_s_sel (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_ce(i_ce), .i_pin(i_select), .o_level(sel_s));
    psr_sync3 #(.RST_VAL(1'b1)) u_s_flt (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_ce(i_ce), .i_pin(i_nfault),
        .o_level(nfault_s));

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] data_reg;
    reg [7:0] dcr_reg;
    reg [7:0] ecr_reg;
    reg [7:0] cap_reg;
    reg [2:0] irq_stat_reg;
    reg [2:0] irq_mask_reg;
    reg [WB-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] rd_ptr_reg;
    reg [AW-1:0] wr_ptr_reg;
    reg [AW:0] cnt_reg;
    reg [1:0] tx_state_reg;
    reg [1:0] byte_idx_reg;
    reg [7:0] xcvr_reg;
    reg xcvr_full_reg;
    reg [15:0] stb_cnt_reg;
    reg [31:0] idle_cnt_reg;

    wire [2:0] mode = ecr_reg[`PSR_ECR_MODE_HI:`PSR_ECR_MODE_LO];
    wire fifo_full = (cnt_reg == FULL_CNT); // RULE19
    wire fifo_empty = (cnt_reg == {(AW+1){1'b0}});
    wire wr_ecr = i_wr && (i_addr == `PSR_OFS_ECR);
    wire fifo_rst = wr_ecr &&
        ((i_wdata[7:5] == `PSR_MODE_BYTE) ||
         (i_wdata[7:5] == `PSR_MODE_STD)); // RULE10
    wire push = i_wr && (i_addr == `PSR_OFS_FIFO) && !fifo_full;
    // sw strobe low blocks new loads and transfer starts
    wire hold = dcr_reg[`PSR_DCR_STROBE]; // RULE1
    wire ecp_fwd = (mode == `PSR_MODE_ECP) && !dcr_reg[`PSR_DCR_DIR]; // RULE17
    wire load = ecp_fwd && !hold && (tx_state_reg == TX_IDLE) &&
        !xcvr_full_reg && !fifo_empty;
    wire pop = load && (byte_idx_reg == LAST_B);
    wire [WB-1:0] head = mem[rd_ptr_reg];
    wire [7:0] head_byte = head[byte_idx_reg*8 +: 8];
    wire hw_strobe = (tx_state_reg == TX_STROBE);
    wire tx_done = (tx_state_reg == TX_WAIT) && !busy_s;
    wire stall_evt = ecp_fwd && !fifo_empty &&
        (idle_cnt_reg == TIMEOUT_CYC - 1); // RULE12

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            data_reg <= 8'h00;
            dcr_reg <= `PSR_DCR_RST;
            ecr_reg <= `PSR_ECR_RST;
            irq_mask_reg <= 3'h0;
        end else if (i_ce) begin
            if (i_wr && i_addr == `PSR_OFS_DATA) begin
                data_reg <= i_wdata[7:0];
            end
            if (i_wr && i_addr == `PSR_OFS_DCR) begin
                dcr_reg <= i_wdata[7:0];
            end
            if (wr_ecr) begin
                // 0x74 sets service and error disable bits
                ecr_reg <= {i_wdata[7:2], 2'h0}; // RULE18
            end
            if (i_wr && i_addr == `PSR_OFS_IRQ_MASK) begin
                irq_mask_reg <= i_wdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // fifo
    // ----------------------------------------
    always @(posedge i_core_clk) begin
        if (i_ce && push) begin
            mem[wr_ptr_reg] <= i_wdata[WB-1:0];
        end
    end

    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_ptr_reg <= {AW{1'b0}};
            wr_ptr_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            cap_reg <= {FAULT_WITH_SVC, 7'h04};
        end else if (i_ce) begin
            if (fifo_rst) begin
                rd_ptr_reg <= {AW{1'b0}};
                wr_ptr_reg <= {AW{1'b0}};
                cnt_reg <= {(AW+1){1'b0}};
                // head residue: bytes left of a partial head word
                cap_reg[2] <= !xcvr_full_reg; // RULE5
                if (!fifo_empty && byte_idx_reg != 2'h0) begin // RULE3
                    cap_reg[1:0] <= LAST_B - byte_idx_reg + 2'h1; // RULE4 RULE6
                end else begin
                    cap_reg[1:0] <= 2'h3;
                end
            end else begin
                if (push) begin
                    wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
                end
                if (pop) begin
                    rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
                end
                if (push && !pop) begin
                    cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
                end else if (pop && !push) begin
                    cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
                end
            end
        end
    end

    // ----------------------------------------
    // forward transmit engine
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_state_reg <= TX_IDLE;
            byte_idx_reg <= 2'h0;
            xcvr_reg <= 8'h00;
            xcvr_full_reg <= 1'b0;
            stb_cnt_reg <= 16'h0000;
        end else if (i_ce) begin
            if (fifo_rst) begin
                tx_state_reg <= TX_IDLE;
                byte_idx_reg <= 2'h0;
                xcvr_full_reg <= 1'b0;
            end else begin
                if (load) begin
                    xcvr_reg <= head_byte;
                    xcvr_full_reg <= 1'b1;
                    byte_idx_reg <= pop ? 2'h0 : byte_idx_reg + 2'h1;
                end
                case (tx_state_reg)
                    TX_IDLE: begin
                        if (xcvr_full_reg && !hold && ecp_fwd &&
                            !busy_s) begin // RULE1
                            tx_state_reg <= TX_SETUP;
                        end
                    end
                    TX_SETUP: begin
                        stb_cnt_reg <= STB_CYC;
                        tx_state_reg <= TX_STROBE;
                    end
                    TX_STROBE: begin
                        // minimum strobe width before busy is honoured
                        if (stb_cnt_reg != 16'h0000) begin
                            stb_cnt_reg <= stb_cnt_reg - 16'h0001;
                        end else if (busy_s) begin
                            tx_state_reg <= TX_WAIT;
                        end
                    end
                    TX_WAIT: begin
                        if (tx_done) begin
                            xcvr_full_reg <= 1'b0;
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                    default: begin
                        tx_state_reg <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // stall timer and interrupts
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            idle_cnt_reg <= 32'h0000_0000;
            irq_stat_reg <= 3'h0;
        end else if (i_ce) begin
            if (tx_done || !ecp_fwd || fifo_empty || stall_evt) begin
                idle_cnt_reg <= 32'h0000_0000;
            end else begin
                idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
            end
            // set wins over write-one-to-clear
            irq_stat_reg <= (irq_stat_reg &
                ~((i_wr && i_addr == `PSR_OFS_IRQ_STAT) ?
                  i_wdata[2:0] : 3'h0)) |
                {stall_evt, tx_done && fifo_empty,
                 !nfault_s}; // RULE13
        end
    end

    // fault passes unless service irq enabled on a design without support
    wire flt_ok = FAULT_WITH_SVC || ecr_reg[`PSR_ECR_SVC]; // RULE14
    wire [2:0] gate = {!ecr_reg[`PSR_ECR_SVC],
        !ecr_reg[`PSR_ECR_SVC],
        !ecr_reg[`PSR_ECR_ERRDIS] && flt_ok};
    assign o_irq = |(irq_stat_reg & irq_mask_reg & gate);

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_ce) begin
            o_rdata <= 32'h0000_0000;
            if (i_rd) begin
                case (i_addr)
                    `PSR_OFS_DATA: o_rdata[7:0] <= dcr_reg[`PSR_DCR_DIR] ?
                        i_pd_in : data_reg;
                    `PSR_OFS_DSR: o_rdata[7:0] <= {!busy_s, nack_s, pe_s,
                        sel_s, nfault_s, 3'h0};
                    `PSR_OFS_DCR: o_rdata[7:0] <= dcr_reg;
                    `PSR_OFS_CAP: o_rdata[7:0] <= cap_reg;
                    `PSR_OFS_ECR: o_rdata[7:0] <= {ecr_reg[7:2], fifo_full,
                        fifo_empty}; // RULE19
                    `PSR_OFS_IRQ_STAT: o_rdata[2:0] <= irq_stat_reg;
                    `PSR_OFS_IRQ_MASK: o_rdata[2:0] <= irq_mask_reg;
                    default: o_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    assign o_pd_out = ecp_fwd ? xcvr_reg : data_reg;
    assign o_pd_oe = !dcr_reg[`PSR_DCR_DIR]; // RULE7
    assign o_nstrobe = !(dcr_reg[`PSR_DCR_STROBE] || hw_strobe);
    assign o_nautofd = !dcr_reg[`PSR_DCR_AUTOFD];
    assign o_ninit = dcr_reg[`PSR_DCR_INIT];
    assign o_nselectin = !dcr_reg[`PSR_DCR_SELIN];
endmodule // psr_port

// ---- design/psr_sync3.v ----
`timescale 1ns/1ps
// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
module psr_sync3 #(
    parameter RST_VAL = 1'b1
) (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_pin,
    output reg o_level
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            o_level <= RST_VAL;
        end else if (i_ce) begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                o_level <= s3_reg;
            end
        end
    end
endmodule // psr_sync3

// ---- testbench/psr_periph.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// cable peripheral model
// ----------------------------------------
module psr_periph (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_nstrobe,
    input wire i_ninit,
    input wire [7:0] i_pd,
    input wire i_pd_oe,
    input wire i_stall,
    input wire i_req,
    output reg o_busy,
    output reg o_pe,
    output wire o_nack,
    output wire o_select,
    output wire o_nfault,
    output wire [7:0] o_pd
);
reg [7:0] pat_reg;
assign o_nack = 1'b1;
assign o_select = 1'b1;
assign o_nfault = ~i_req;
// released lines show a moving pattern
assign o_pd = i_pd_oe ? i_pd : pat_reg;
always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_busy <= 1'b0;
        o_pe <= 1'b1;
        pat_reg <= 8'h5a;
    end else begin
        pat_reg <= pat_reg + 8'h3b;
        o_busy <= i_stall | ~i_nstrobe;
        o_pe <= i_ninit;
    end
end
endmodule // psr_periph

// ---- testbench/psr_port_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module psr_port_monitor #(
    parameter FAULT_WITH_SVC = 1'b1
) (
    input wire i_core_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [31:0] o_rdata,
    input wire o_pd_oe,
    input wire o_nstrobe,
    input wire o_ninit,
    input wire o_irq
);
default clocking cb @(posedge i_core_clk); endclocking
default disable iff (!i_nrst);
wire dcr_wr = i_wr && i_ce && i_addr == 4'h2;
wire ecr_wr = i_wr && i_ce && i_addr == 4'h5;
wire ecr_rst = ecr_wr && i_wdata[7:6] == 2'h0;
wire ecr_rd = i_rd && i_ce && i_addr == 4'h5;
wire cap_rd = i_rd && i_ce && i_addr == 4'h4;
a_strobe_block: assert property (
    dcr_wr && i_wdata[0] |=> !o_nstrobe) else $error("strobe not held low");
a_oe_off: assert property (
    dcr_wr && i_wdata[5] |=> !o_pd_oe) else $error("data still driven");
a_oe_on: assert property (
    dcr_wr && !i_wdata[5] |=> o_pd_oe) else $error("data not driven");
a_init_level: assert property (
    dcr_wr |=> o_ninit == $past(i_wdata[2])) else $error("init level wrong");
a_fifo_reset: assert property (
    ecr_rst ##1 ecr_rd |=> o_rdata[1:0] == 2'h1)
    else $error("fifo not reset");
a_mode_code: assert property (
    ecr_wr ##1 ecr_rd |=> o_rdata[7:5] == $past(i_wdata[7:5], 2))
    else $error("mode readback wrong");
a_cap_flag: assert property (
    cap_rd |=> o_rdata[7] == FAULT_WITH_SVC)
    else $error("capability bit 7 wrong");
a_irq_masked: assert property (
    i_wr && i_ce && i_addr == 4'h7 && i_wdata[7:0] == 8'h00 |=> !o_irq)
    else $error("irq with mask clear");
a_irq_quiet: assert property (
    ecr_wr && i_wdata[4] && i_wdata[2] |=> !o_irq)
    else $error("irq after masking ecr write");
endmodule // psr_port_monitor
bind psr_port psr_port_monitor #(.FAULT_WITH_SVC(FAULT_WITH_SVC)) u_mon (
    .i_core_clk, .i_nrst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_pd_oe, .o_nstrobe, .o_ninit, .o_irq
);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port testbench
// ----------------------------------------
module tb_top;
localparam DEPTH = 16;
reg i_core_clk = 1'b0;
reg i_nrst = 1'b0;
reg [3:0] i_addr = 4'h0;
reg [31:0] i_wdata = 32'h0;
reg i_wr = 1'b0;
reg i_rd = 1'b0;
reg stall = 1'b0;
reg req = 1'b0;
wire [31:0] rdata;
wire [7:0] pd_out;
wire [7:0] pd_in;
wire pd_oe, nstrobe, ninit, busy, pe, nack, sel, nfault, irq;
wire nautofd, nselectin;
integer bad_count = 0;
integer total_checks = 0;
integer i;
always #12.5 i_core_clk = ~i_core_clk;
psr_port #(.DEPTH(DEPTH), .TIMEOUT_CYC(50)) dut (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ce(1'b1),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .o_pd_out(pd_out), .o_pd_oe(pd_oe), .i_pd_in(pd_in),
    .o_nstrobe(nstrobe), .o_nautofd(nautofd), .o_ninit(ninit),
    .o_nselectin(nselectin),
    .i_nack(nack), .i_busy(busy), .i_pe(pe), .i_select(sel),
    .i_nfault(nfault), .o_irq(irq));
psr_periph u_per (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_nstrobe(nstrobe),
    .i_ninit(ninit), .i_pd(pd_out), .i_pd_oe(pd_oe), .i_stall(stall),
    .i_req(req), .o_busy(busy), .o_pe(pe), .o_nack(nack),
    .o_select(sel), .o_nfault(nfault), .o_pd(pd_in));
task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    end
endtask
task waitc(input integer n);
    begin
        repeat (n) @(posedge i_core_clk);
        #1;
    end
endtask
task wr(input [3:0] a, input [31:0] d);
    begin
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    end
endtask
// masked read compare, data in the cycle after the strobe
task rd(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 chk(rdata & m, e);
    end
endtask
task t_reset;
    begin
        rd(4'h5, 32'hff, 32'h35);
        chk({pd_oe, nstrobe, ninit}, 32'h7);
        wr(4'h0, 32'ha5);
        chk(pd_out, 32'ha5);
        rd(4'h0, 32'hff, 32'ha5);
        wr(4'h2, 32'h0e);
        chk({nautofd, nselectin, ninit}, 32'h1);
        wr(4'h2, 32'h04);
        wr(4'h5, 32'h14);
        rd(4'h5, 32'he0, 32'h00);
        wr(4'h5, 32'h74);
        rd(4'h5, 32'he0, 32'h60);
        chk(irq, 0);
        wr(4'h5, 32'h34);
        rd(4'h5, 32'he3, 32'h21);
        $display("t_reset done");
    end
endtask
task t_fill;
    begin
        wr(4'h2, 32'h05);
        chk(nstrobe, 0);
        wr(4'h5, 32'h74);
        for (i = 1; i < DEPTH; i = i + 1) wr(4'h3, i);
        rd(4'h5, 32'h03, 32'h00);
        wr(4'h3, 32'haa);
        rd(4'h5, 32'h03, 32'h02);
        wr(4'h3, 32'h55);
        waitc(20);
        chk(nstrobe, 0);
        wr(4'h5, 32'h34);
        rd(4'h5, 32'h03, 32'h01);
        rd(4'h4, 32'h87, 32'h87);
        $display("t_fill done");
    end
endtask
task t_stall;
    begin
        wr(4'h6, 32'h07);
        wr(4'h2, 32'h04);
        stall <= 1'b1;
        wr(4'h5, 32'h74);
        wr(4'h3, 32'hc3);
        wr(4'h3, 32'h3c);
        rd(4'h6, 32'h04, 32'h00);
        waitc(80);
        rd(4'h6, 32'h04, 32'h04);
        chk(pd_out, 32'hc3);
        wr(4'h2, 32'h05);
        for (i = 1; i < DEPTH; i = i + 1) wr(4'h3, i);
        rd(4'h5, 32'h03, 32'h02);
        wr(4'h5, 32'h34);
        rd(4'h4, 32'h07, 32'h03);
        stall <= 1'b0;
        wr(4'h6, 32'h07);
        $display("t_stall done");
    end
endtask
task t_recover;
    begin
        wr(4'h2, 32'h25);
        chk(pd_oe, 0);
        wr(4'h2, 32'h21);
        waitc(8);
        rd(4'h1, 32'h20, 32'h00);
        wr(4'h2, 32'h20);
        chk(nstrobe, 1);
        wr(4'h2, 32'h24);
        waitc(8);
        rd(4'h1, 32'h20, 32'h20);
        wr(4'h2, 32'h04);
        chk(pd_oe, 1);
        $display("t_recover done");
    end
endtask
task t_irq;
    begin
        wr(4'h5, 32'h24);
        wr(4'h6, 32'h07);
        wr(4'h7, 32'h01);
        req <= 1'b1;
        waitc(8);
        chk(irq, 1);
        rd(4'h6, 32'h01, 32'h01);
        wr(4'h5, 32'h34);
        chk(irq, 0);
        wr(4'h5, 32'h20);
        chk(irq, 1);
        wr(4'h7, 32'h00);
        chk(irq, 0);
        wr(4'h7, 32'h01);
        req <= 1'b0;
        waitc(8);
        wr(4'h6, 32'h01);
        chk(irq, 0);
        $display("t_irq done");
    end
endtask
task finish_test;
    begin
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
endtask
initial begin
    repeat (20) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    waitc(1);
    t_reset;
    t_fill;
    t_stall;
    t_recover;
    t_irq;
    finish_test;
end
initial begin
    #100000;
    bad_count = bad_count + 1;
    finish_test;
end
endmodule // tb_top
